// [common/fspg_pkg.sv]
package fspg_pkg;
  localparam int ADDR_W = 16;
  localparam logic [7:0] PC_LOW_MASK = 8'h00;
  // boundary decode: boot size fuse code -> loader start page (word address upper byte)
  localparam logic [7:0] LOADER_START_0 = 8'hF0;
  localparam logic [7:0] LOADER_START_1 = 8'hF8;
  localparam logic [7:0] LOADER_START_2 = 8'hFC;
  localparam logic [7:0] LOADER_START_3 = 8'hFE;
  localparam logic [7:0] HALT_START = 8'hE0;
  localparam logic [1:0] PROT_FREE = 2'h3;
  localparam logic [1:0] PROT_NOSTORE = 2'h2;
  localparam logic [1:0] PROT_NONE = 2'h0;
  localparam logic [1:0] PROT_NOLOAD = 2'h1;
  localparam int OP_TIME_US = 4;
  localparam int CLK_MHZ = 20;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_LOCK = 4'h2;
  localparam int CTRL_READ_EN_BIT = 0;
  localparam int LOCK_LOADER_LO_BIT = 2;
  typedef struct packed {
    logic store;
    logic load;
    logic [ADDR_W-1:0] pc;
    logic [ADDR_W-1:0] target;
  } fspg_req_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } fspg_state_e;
endpackage : fspg_pkg

// [core/fspg_guard.sv]
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module fspg_guard
  import fspg_pkg::*;
#(
  parameter int OP_CYC = OP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire fspg_req_s req,
  input wire logic [1:0] bootSizeFuses,
  input wire logic vectorsInLoader,
  input wire logic [1:0] generalLock,
  input wire logic chipErase,
  input wire logic pgmLockWr,
  input wire logic [3:0] pgmLockData,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic startOp,
  output logic cpuStall,
  output logic rwAreaBlock,
  output logic loadGranted,
  output logic irqSuppress
);
  function automatic logic inLoader(input logic [ADDR_W-1:0] a, input logic [1:0] bs);
    logic [7:0] start;
    start = (bs == 2'h0) ? LOADER_START_0 : (bs == 2'h1) ? LOADER_START_1 :
            (bs == 2'h2) ? LOADER_START_2 : LOADER_START_3;
    return a[ADDR_W-1 -: 8] >= start;
  endfunction : inLoader

  fspg_state_e state_q, state_d;
  logic [15:0] cnt_q;
  logic [1:0] appProt_q;
  logic [1:0] ldrProt_q;
  logic busy_q;
  logic haltOp_q;
  logic [7:0] rdata_q;
  logic startOp_q, loadGranted_q, irqSup_q;

  wire logic pcLoader = inLoader(req.pc, bootSizeFuses);
  wire logic tgtLoader = inLoader(req.target, bootSizeFuses);
  wire logic tgtHalt = req.target[ADDR_W-1 -: 8] >= HALT_START;
  wire logic [1:0] tgtProt = tgtLoader ? ldrProt_q : appProt_q;
  // generalLock is deliberately not consulted here
  wire logic storeLocked = !tgtProt[0];
  wire logic loadLocked = !tgtProt[1] && (pcLoader != tgtLoader);
  wire logic storeOk = req.store && pcLoader && !storeLocked && state_q == ST_IDLE;
  wire logic loadOk = req.load && !loadLocked && !(busy_q && !tgtHalt);
  wire logic readEnWr = regWr && regAddr == REG_CTRL && regWdata[CTRL_READ_EN_BIT];
  wire logic irqMute = (pcLoader ? (!ldrProt_q[1] && !vectorsInLoader)
                                 : (!appProt_q[1] && vectorsInLoader));
  wire logic opEnd = state_q == ST_BUSY && cnt_q == 16'(OP_CYC - 1);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (storeOk) state_d = ST_BUSY;
      ST_BUSY: if (opEnd) state_d = ST_DONE;
      ST_DONE: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      haltOp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_q == ST_BUSY) ? cnt_q + 16'h0001 : 16'h0000;
      // held in a flop for the whole operation so the stall pin is glitch free
      haltOp_q <= storeOk ? tgtHalt : (haltOp_q && !opEnd);
    end
  end

  // busy sets on start and stays until software re-opens the area
  always_ff @(posedge clk) begin
    if (rst) busy_q <= 1'b0;
    else if (storeOk) busy_q <= 1'b1;
    else if (readEnWr && state_q == ST_IDLE) busy_q <= 1'b0;
  end

  // protect bits only move towards programmed unless reset or chip erase
  always_ff @(posedge clk) begin
    if (rst) begin
      appProt_q <= PROT_FREE;
      ldrProt_q <= PROT_FREE;
    end else if (chipErase) begin
      appProt_q <= PROT_FREE;
      ldrProt_q <= PROT_FREE;
    end else if (pgmLockWr) begin
      appProt_q <= appProt_q & pgmLockData[1:0];
      ldrProt_q <= ldrProt_q & pgmLockData[3:2];
    end else if (regWr && regAddr == REG_LOCK && pcLoader) begin
      appProt_q <= appProt_q & regWdata[1:0];
      ldrProt_q <= ldrProt_q & regWdata[3:2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      startOp_q <= 1'b0;
      loadGranted_q <= 1'b0;
      irqSup_q <= 1'b0;
    end else begin
      rdata_q <= !regRd ? 8'h00 :
                 regAddr == REG_STATUS ? {6'h00, busy_q, state_q != ST_IDLE} :
                 regAddr == REG_LOCK ? {4'h0, ldrProt_q, appProt_q} : 8'h00;
      startOp_q <= storeOk;
      loadGranted_q <= loadOk;
      irqSup_q <= irqMute;
    end
  end

  assign regRdata = rdata_q;
  assign startOp = startOp_q;
  assign cpuStall = haltOp_q;
  assign rwAreaBlock = busy_q;
  assign loadGranted = loadGranted_q;
  assign irqSuppress = irqSup_q;

  // length of the current stall, so its bound needs no long repetition
  logic [15:0] stallRun_q;

  always_ff @(posedge clk) begin
    if (rst) stallRun_q <= 16'h0000;
    else if (cpuStall) stallRun_q <= stallRun_q + 16'h0001;
    else stallRun_q <= 16'h0000;
  end

  // all checks below share one clock and one reset
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  // who may start a programming operation

  a_app_store_ignored: assert property (
    req.store && !pcLoader
    |=> !startOp
  ) else $error("store from application started op");

  a_loader_store_starts: assert property (
    req.store && pcLoader && !storeLocked && state_q == ST_IDLE
    |=> startOp
  ) else $error("permitted loader store did not start");

  a_no_start_busy: assert property (
    req.store && state_q != ST_IDLE
    |=> !startOp
  ) else $error("store accepted while op running");

  a_locked_store: assert property (
    req.store && storeLocked
    |=> !startOp
  ) else $error("locked store accepted");

  // section decode

  a_boundary_low: assert property (
    bootSizeFuses == 2'h0 && req.pc[ADDR_W-1 -: 8] >= LOADER_START_0
    |-> pcLoader
  ) else $error("large loader area not decoded");

  a_boundary_high: assert property (
    bootSizeFuses == 2'h3 && req.pc[ADDR_W-1 -: 8] < LOADER_START_3
    |-> !pcLoader
  ) else $error("small loader area decoded too wide");

  a_loader_in_halt: assert property (
    tgtLoader
    |-> tgtHalt
  ) else $error("loader area outside halting area");

  // stall behaviour while an operation runs

  a_rw_no_stall: assert property (
    storeOk && !tgtHalt
    |=> !cpuStall ##1 !cpuStall
  ) else $error("stall on rw program");

  a_halt_stall: assert property (
    storeOk && tgtHalt
    |=> cpuStall ##1 cpuStall
  ) else $error("no stall on halting program");

  a_stall_bounded: assert property (
    cpuStall
    |-> stallRun_q < 16'(OP_CYC)
  ) else $error("stall outlasts the operation");

  a_op_length: assert property (
    state_q == ST_BUSY
    |-> cnt_q < 16'(OP_CYC)
  ) else $error("operation counter overran");

  a_stall_needs_start: assert property (
    $rose(cpuStall)
    |-> startOp
  ) else $error("stall without accepted store");

  a_state_legal: assert property (
    1'b1
    |-> state_q inside {ST_IDLE, ST_BUSY, ST_DONE}
  ) else $error("illegal sequencer state");

  // read-while-write area blocking and its busy flag

  a_busy_follows_start: assert property (
    startOp
    |-> rwAreaBlock
  ) else $error("busy not set at start");

  a_load_blocked: assert property (
    req.load && busy_q && !tgtHalt
    |=> !loadGranted
  ) else $error("rw read while busy");

  a_busy_flag_read: assert property (
    regRd && regAddr == REG_STATUS && rwAreaBlock
    |=> regRdata[1]
  ) else $error("busy flag read as zero");

  a_busy_clear: assert property (
    readEnWr && state_q == ST_IDLE && !storeOk
    |=> !rwAreaBlock
  ) else $error("read enable did not clear busy");

  a_rd_idle_zero: assert property (
    !regRd
    |=> regRdata == 8'h00
  ) else $error("read data without read strobe");

  a_grant_needs_load: assert property (
    loadGranted
    |-> $past(req.load)
  ) else $error("grant without load");

  // protect bits

  a_lock_sticky: assert property (
    !chipErase
    |=> (appProt_q & ~$past(appProt_q)) == 2'h0
  ) else $error("lock bit unprogrammed");

  a_ldr_sticky: assert property (
    !chipErase
    |=> (ldrProt_q & ~$past(ldrProt_q)) == 2'h0
  ) else $error("loader lock bit unprogrammed");

  a_erase_frees: assert property (
    chipErase
    |=> appProt_q == PROT_FREE && ldrProt_q == PROT_FREE
  ) else $error("chip erase left protection");

  // application area modes

  a_app_free_load: assert property (
    req.load && !tgtLoader && appProt_q == PROT_FREE && !busy_q
    |=> loadGranted
  ) else $error("free application load refused");

  a_app_nostore: assert property (
    req.store && !tgtLoader && appProt_q == PROT_NOSTORE
    |=> !startOp
  ) else $error("application store accepted in mode 2");

  a_app_full_lock: assert property (
    req.load && pcLoader && !tgtLoader && appProt_q == PROT_NONE
    |=> !loadGranted
  ) else $error("application read leak in mode 3");

  a_app_noload: assert property (
    req.load && pcLoader && !tgtLoader && appProt_q == PROT_NOLOAD
    |=> !loadGranted
  ) else $error("application read leak in mode 4");

  a_app_irq_mute: assert property (
    !pcLoader && vectorsInLoader && !appProt_q[1]
    |=> irqSuppress
  ) else $error("interrupts open in application");

  // loader area modes

  a_ldr_nostore: assert property (
    req.store && tgtLoader && ldrProt_q == PROT_NOSTORE
    |=> !startOp
  ) else $error("loader store accepted in mode 2");

  a_ldr_full_lock: assert property (
    req.store && tgtLoader && ldrProt_q == PROT_NONE
    |=> !startOp
  ) else $error("loader store accepted in mode 3");

  a_mode_load: assert property (
    req.load && !pcLoader && tgtLoader && !ldrProt_q[1]
    |=> !loadGranted
  ) else $error("loader read leak");

  a_ldr_irq_mute: assert property (
    pcLoader && !vectorsInLoader && !ldrProt_q[1]
    |=> irqSuppress
  ) else $error("interrupts open in loader");

  // main scenarios worth seeing at least once
  c_start: cover property (startOp);
  c_stall: cover property (cpuStall);
  c_clear: cover property ($fell(rwAreaBlock));
  c_rw_refused: cover property (req.load && busy_q && !tgtHalt);
  c_lock_write: cover property (pgmLockWr && pgmLockData != 4'hF);
endmodule : fspg_guard
`default_nettype wire

// [test/fspg_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fspg_cpu_model
  import fspg_pkg::*;
(
  input wire logic clk,
  output var fspg_req_s req
);
  initial req = '0;
  // busy-area loads only serve refusal tests; normal flow clears busy first
  task automatic issue(input logic st, input logic ld, input logic [15:0] pc,
                       input logic [15:0] tgt);
    @(posedge clk);
    req <= '{store: st, load: ld, pc: pc, target: tgt};
    @(posedge clk);
    req.store <= 1'b0;
    req.load <= 1'b0;
  endtask : issue
endmodule : fspg_cpu_model
`default_nettype wire

// [test/fspg_guard_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED t=%0t mismatch", $time); end end
module fspg_guard_bench
  import fspg_pkg::*;
;
  localparam int OPC = 5;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fspg_req_s req;
  logic [1:0] bootSizeFuses = 2'h3;
  logic vectorsInLoader = 1'b1;
  logic [1:0] generalLock = 2'h0;
  logic chipErase = 1'b0;
  logic pgmLockWr = 1'b0;
  logic [3:0] pgmLockData = 4'hF;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic startOp, cpuStall, rwAreaBlock, loadGranted, irqSuppress;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  fspg_cpu_model i_fspg_cpu_model (.clk(clk), .req(req));
  fspg_guard #(.OP_CYC(OPC)) i_fspg_guard (.clk(clk), .rst(rst), .req(req),
    .bootSizeFuses(bootSizeFuses), .vectorsInLoader(vectorsInLoader), .generalLock(generalLock),
    .chipErase(chipErase), .pgmLockWr(pgmLockWr), .pgmLockData(pgmLockData), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .startOp(startOp),
    .cpuStall(cpuStall), .rwAreaBlock(rwAreaBlock), .loadGranted(loadGranted),
    .irqSuppress(irqSuppress));
  task automatic stop_test;
    $display("mismatches %0d of %0d checks", fails, checked);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      stop_test();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 `CHK(regRdata, exp)
  endtask : rd
  task automatic op(input logic st, input logic ld, input logic [15:0] pc,
                    input logic [15:0] tgt, input logic expS, input logic expG);
    i_fspg_cpu_model.issue(st, ld, pc, tgt);
    #1 `CHK(startOp, expS)
    `CHK(loadGranted, expG)
  endtask : op
  task automatic post(input logic s, input logic b);
    @(posedge clk);
    #1 `CHK(cpuStall, s)
    `CHK(rwAreaBlock, b)
  endtask : post
  // busy only clears once the operation has run out, so wait past OP_CYC first
  task automatic finish_op;
    repeat (OPC + 3) @(posedge clk);
    wr(REG_CTRL, 8'h01);
  endtask : finish_op
  task automatic lock(input logic [3:0] d);
    @(posedge clk);
    pgmLockWr <= 1'b1;
    pgmLockData <= d;
    @(posedge clk);
    pgmLockWr <= 1'b0;
  endtask : lock
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(REG_LOCK, 8'h0F);
    rd(4'hF, 8'h00);
    op(1'b1, 1'b0, 16'h1000, 16'h2000, 1'b0, 1'b0);
    op(1'b1, 1'b0, 16'hFF00, 16'h2000, 1'b1, 1'b0);
    post(1'b0, 1'b1);
    repeat (OPC + 3) @(posedge clk);
    rd(REG_STATUS, 8'h02);
    op(1'b0, 1'b1, 16'hFF00, 16'h2000, 1'b0, 1'b0);
    wr(REG_CTRL, 8'h01);
    rd(REG_STATUS, 8'h00);
    op(1'b0, 1'b1, 16'hFF00, 16'h2000, 1'b0, 1'b1);
    op(1'b1, 1'b0, 16'hFF00, 16'hFF10, 1'b1, 1'b0);
    post(1'b1, 1'b1);
    finish_op();
    @(posedge clk) bootSizeFuses <= 2'h0;
    op(1'b1, 1'b0, 16'hF400, 16'h2000, 1'b1, 1'b0);
    finish_op();
    @(posedge clk) bootSizeFuses <= 2'h3;
    op(1'b1, 1'b0, 16'hF400, 16'h2000, 1'b0, 1'b0);
    @(posedge clk) generalLock <= 2'h3;
    lock(4'hE);
    rd(REG_LOCK, 8'h0E);
    op(1'b1, 1'b0, 16'hFF00, 16'h2000, 1'b0, 1'b0);
    op(1'b0, 1'b1, 16'hFF00, 16'h2000, 1'b0, 1'b1);
    lock(4'hC);
    op(1'b0, 1'b1, 16'hFF00, 16'h2000, 1'b0, 1'b0);
    op(1'b0, 1'b1, 16'h1000, 16'h1000, 1'b0, 1'b1);
    `CHK(irqSuppress, 1'b1)
    lock(4'hF);
    rd(REG_LOCK, 8'h0C);
    @(posedge clk) chipErase <= 1'b1;
    @(posedge clk) chipErase <= 1'b0;
    rd(REG_LOCK, 8'h0F);
    lock(4'h7);
    op(1'b0, 1'b1, 16'h1000, 16'hFF10, 1'b0, 1'b0);
    @(posedge clk) vectorsInLoader <= 1'b0;
    op(1'b0, 1'b1, 16'hFF00, 16'h2000, 1'b0, 1'b1);
    `CHK(irqSuppress, 1'b1)
    op(1'b1, 1'b0, 16'hFF00, 16'hFF10, 1'b1, 1'b0);
    finish_op();
    stop_test();
  end
endmodule : fspg_guard_bench
`default_nettype wire
